// file: verilog/scc_pkg.sv
package scc_pkg;
    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int MS_PS = 1000000000;
    localparam int CYCLES_PER_MS = MS_PS / CLK_PERIOD_PS;
    localparam int FAIL_PULSE_MS = 200;
    localparam int OBJ_FAIL_MS = 1000;
    localparam int TIMEOUT_UNIT_MS = 100;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_VLIM = 8'h04;
    localparam logic [7:0] REG_DLIM = 8'h08;
    localparam logic [7:0] REG_TIME = 8'h0c;
    localparam logic [7:0] REG_CMD = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] VLIM_RESET = 32'h0000_5014;
    localparam logic [31:0] DLIM_RESET = 32'h0014_0c64;
    localparam logic [31:0] TIME_RESET = 32'h0064_0064;
    // ctrl fields
    localparam int CTRL_SMODE_LSB = 0;
    localparam int CTRL_UMODE_LSB = 2;
    localparam int CTRL_MMODE_LSB = 5;
    localparam int CTRL_PAIR_LSB = 8;
    // limit fields
    localparam int VLIM_LIVE_LSB = 8;
    localparam int DLIM_DV_LSB = 10;
    localparam int DLIM_ANG_LSB = 16;
    localparam int TIME_TOUT_LSB = 16;
    // synchronism modes
    localparam logic [1:0] SMODE_OFF = 2'h0;
    localparam logic [1:0] SMODE_ASYNC = 2'h1;
    localparam logic [1:0] SMODE_SYNC = 2'h2;
    // voltage check modes
    localparam logic [2:0] UMODE_BOTH_SIDES_DEAD = 3'h0;
    localparam logic [2:0] UMODE_REFERENCE_DEAD_COMPARISON_LIVE = 3'h1;
    localparam logic [2:0] UMODE_REFERENCE_LIVE_COMPARISON_DEAD = 3'h2;
    localparam logic [2:0] UMODE_DEAD_REF = 3'h3;
    localparam logic [2:0] UMODE_DEAD_CMP = 3'h4;
    localparam logic [2:0] UMODE_ONE_DEAD = 3'h5;
    localparam logic [2:0] UMODE_ALL = 3'h6;
    // measuring modes with two extra channels
    localparam logic [2:0] MMODE_TWO_FIRST = 3'h4;
    // stage 2 pair select
    localparam logic [1:0] PAIR_MAIN_SECOND = 2'h0;
    localparam logic [1:0] PAIR_MAIN_THIRD = 2'h1;
    localparam logic [1:0] PAIR_SECOND_THIRD = 2'h2;
    // geometry
    localparam int HALF_TURN_DEG = 180;
    localparam int FULL_TURN_DEG = 360;
    localparam int MHZ_MS_SCALE = 1000000;
    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_FAIL, ST_CBWAIT} scc_state_type;
endpackage

// file: verilog/scc_stage_if.sv
`timescale 1ns/1ps
interface scc_stage_if;
    logic tick;
    logic enable;
    logic bypass;
    logic [1:0] smode;
    logic [2:0] umode;
    logic [7:0] dead_lim;
    logic [7:0] live_lim;
    logic [9:0] df_lim;
    logic [5:0] dv_lim;
    logic [6:0] ang_lim;
    logic [9:0] cb_ms;
    logic [12:0] tout;
    logic [7:0] v_ref;
    logic [7:0] v_cmp;
    logic [15:0] f_ref;
    logic [15:0] f_cmp;
    logic [8:0] p_ref;
    logic [8:0] p_cmp;
    logic start;
    logic cb_closed;
    logic req;
    logic ok;
    logic fail;
    logic close;
    logic obj_fail;
    modport top (output tick, enable, bypass, smode, umode, dead_lim, live_lim, df_lim,
        dv_lim, ang_lim, cb_ms, tout, v_ref, v_cmp, f_ref, f_cmp, p_ref, p_cmp, start,
        cb_closed, input req, ok, fail, close, obj_fail);
    modport stage (input tick, enable, bypass, smode, umode, dead_lim, live_lim, df_lim,
        dv_lim, ang_lim, cb_ms, tout, v_ref, v_cmp, f_ref, f_cmp, p_ref, p_cmp, start,
        cb_closed, output req, ok, fail, close, obj_fail);
endinterface

// file: verilog/scc_stage.sv
`timescale 1ns/1ps
module scc_stage (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // settings, measurements and results
    scc_stage_if.stage s
);
    scc_pkg::scc_state_type state;
    logic [19:0] cnt;
    logic close;
    logic obj_fail;
    wire ref_dead = s.v_ref < s.dead_lim;
    wire cmp_dead = s.v_cmp < s.dead_lim;
    wire ref_live = s.v_ref > s.live_lim;
    wire cmp_live = s.v_cmp > s.live_lim;
    wire [2:0] combo = {ref_live && cmp_dead, ref_dead && cmp_live, ref_dead && cmp_dead};
    wire [2:0] allowed = (s.umode == scc_pkg::UMODE_BOTH_SIDES_DEAD) ? 3'h1 :
        (s.umode == scc_pkg::UMODE_REFERENCE_DEAD_COMPARISON_LIVE) ? 3'h2 :
        (s.umode == scc_pkg::UMODE_REFERENCE_LIVE_COMPARISON_DEAD) ? 3'h4 :
        (s.umode == scc_pkg::UMODE_DEAD_REF) ? 3'h3 :
        (s.umode == scc_pkg::UMODE_DEAD_CMP) ? 3'h5 :
        (s.umode == scc_pkg::UMODE_ONE_DEAD) ? 3'h6 :
        (s.umode == scc_pkg::UMODE_ALL) ? 3'h7 : 3'h0;
    wire volt_ok = |(combo & allowed);
    // differences
    wire signed [16:0] df = $signed({1'b0, s.f_cmp}) - $signed({1'b0, s.f_ref});
    wire [15:0] df_abs = df[16] ? 16'(-df) : df[15:0];
    wire [7:0] dv_abs = (s.v_cmp > s.v_ref) ? s.v_cmp - s.v_ref : s.v_ref - s.v_cmp;
    wire signed [9:0] dp_raw = $signed({1'b0, s.p_cmp}) - $signed({1'b0, s.p_ref});
    // signed compare keeps a negative raw angle negative
    wire signed [9:0] half_turn = 10'(scc_pkg::HALF_TURN_DEG);
    wire signed [9:0] dp = (dp_raw > half_turn) ? dp_raw - 10'(scc_pkg::FULL_TURN_DEG) :
        (dp_raw < -half_turn) ? dp_raw + 10'(scc_pkg::FULL_TURN_DEG) : dp_raw;
    wire [8:0] dp_abs = dp[9] ? 9'(-dp) : dp[8:0];
    // live and all differences in limits
    wire diff_ok = ref_live && cmp_live && (df_abs <= {6'h00, s.df_lim}) &&
        (dv_abs <= {2'h0, s.dv_lim}) && (dp_abs <= {2'h0, s.ang_lim});
    wire crit_ok = (s.smode == scc_pkg::SMODE_OFF) ? volt_ok : diff_ok;
    wire sync_ok = s.bypass || crit_ok;
    // angle travelled during breaker time, scaled by one million
    wire [31:0] adv_scaled = 32'(df_abs) * 32'(s.cb_ms) * 32'(scc_pkg::FULL_TURN_DEG);
    wire [31:0] ang_scaled = 32'(dp_abs) * 32'(scc_pkg::MHZ_MS_SCALE);
    wire closing_in = (dp != 10'sh000) && (dp[9] != df[16]) && (df != 17'sh00000);
    wire sync_fire = s.bypass || (diff_ok && (dp == 10'sh000 ||
        (closing_in && ang_scaled <= adv_scaled)));
    wire fire = (s.smode == scc_pkg::SMODE_SYNC) ? sync_fire : sync_ok;
    wire [19:0] tout_ms = 20'(s.tout) * 20'(scc_pkg::TIMEOUT_UNIT_MS);
    wire cnt_hit_tout = cnt + 20'h00001 >= tout_ms;
    wire cnt_hit_fail = cnt + 20'h00001 >= 20'(scc_pkg::FAIL_PULSE_MS);
    wire cnt_hit_obj = cnt + 20'h00001 >= 20'(scc_pkg::OBJ_FAIL_MS);
    assign s.ok = sync_ok;
    assign s.req = state == scc_pkg::ST_REQ;
    assign s.fail = state == scc_pkg::ST_FAIL;
    assign s.close = close;
    assign s.obj_fail = obj_fail;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= scc_pkg::ST_IDLE;
            cnt <= 20'h00000;
            close <= 1'b0;
            obj_fail <= 1'b0;
        end else begin
            close <= 1'b0;
            obj_fail <= 1'b0;
            case (state)
                scc_pkg::ST_IDLE: begin
                    cnt <= 20'h00000;
                    if (s.start && s.enable) begin
                        state <= scc_pkg::ST_REQ;
                    end
                end
                scc_pkg::ST_REQ: begin
                    if (fire) begin
                        close <= 1'b1;
                        cnt <= 20'h00000;
                        state <= scc_pkg::ST_CBWAIT;
                    end else if (s.tick && cnt_hit_tout) begin
                        cnt <= 20'h00000;
                        state <= scc_pkg::ST_FAIL;
                    end else if (s.tick) begin
                        cnt <= cnt + 20'h00001;
                    end
                end
                scc_pkg::ST_FAIL: begin
                    if (s.tick && cnt_hit_fail) begin
                        state <= scc_pkg::ST_IDLE;
                    end else if (s.tick) begin
                        cnt <= cnt + 20'h00001;
                    end
                end
                default: begin
                    if (s.cb_closed) begin
                        state <= scc_pkg::ST_IDLE;
                    end else if (s.tick && cnt_hit_obj) begin
                        obj_fail <= 1'b1;
                        state <= scc_pkg::ST_IDLE;
                    end else if (s.tick) begin
                        cnt <= cnt + 20'h00001;
                    end
                end
            endcase
        end
    end
endmodule

// file: verilog/scc_sync_check.sv
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module scc_sync_check #(
    parameter int CYCLES_PER_MS = scc_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // measurement front end
    input wire logic meas_valid,
    input wire logic [7:0] main_line_to_line_voltage,
    input wire logic [7:0] second_channel_voltage,
    input wire logic [7:0] third_channel_voltage,
    input wire logic [15:0] main_freq,
    input wire logic [15:0] second_freq,
    input wire logic [15:0] third_freq,
    input wire logic [8:0] main_phase,
    input wire logic [8:0] second_phase,
    input wire logic [8:0] third_phase,
    // object control
    input wire logic [1:0] close_cmd,
    input wire logic [1:0] cb_closed,
    input wire logic [1:0] bypass,
    output logic [1:0] cb_close,
    output logic [1:0] object_fail,
    // output matrix
    output logic [1:0] sync_request,
    output logic [1:0] sync_ok,
    output logic [1:0] sync_fail
);
    logic [31:0] ctrl;
    logic [31:0] vlim;
    logic [31:0] dlim;
    logic [31:0] tim;
    logic [1:0] cmd_pulse;
    logic [7:0] wr_addr;
    logic wr_pend;
    logic [17:0] div_cnt;
    logic tick;
    logic [7:0] m_v [3];
    logic [15:0] m_f [3];
    logic [8:0] m_p [3];
    logic [1:0] req_w;
    logic [1:0] ok_w;
    logic [1:0] fail_w;
    logic [1:0] close_w;
    logic [1:0] objf_w;

    scc_stage_if st_if [2] ();

    // bus decode
    wire addr_phase = hsel && htrans[1] && hready;
    wire [7:0] rd_addr = haddr[7:0];
    wire rd_mapped = haddr[31:8] == 24'h000000;
    wire [1:0] smode = ctrl[scc_pkg::CTRL_SMODE_LSB +: 2];
    wire [2:0] umode = ctrl[scc_pkg::CTRL_UMODE_LSB +: 3];
    wire [2:0] mmode = ctrl[scc_pkg::CTRL_MMODE_LSB +: 3];
    wire [1:0] pair = ctrl[scc_pkg::CTRL_PAIR_LSB +: 2];
    wire [31:0] status = {22'h000000, objf_w, close_w, fail_w, ok_w, req_w};
    wire [31:0] rd_val = !rd_mapped ? 32'h0000_0000 :
        (rd_addr == scc_pkg::REG_CTRL) ? ctrl :
        (rd_addr == scc_pkg::REG_VLIM) ? vlim :
        (rd_addr == scc_pkg::REG_DLIM) ? dlim :
        (rd_addr == scc_pkg::REG_TIME) ? tim :
        (rd_addr == scc_pkg::REG_STATUS) ? status : 32'h0000_0000;
    wire wr_ctrl = wr_pend && wr_addr == scc_pkg::REG_CTRL;
    wire wr_vlim = wr_pend && wr_addr == scc_pkg::REG_VLIM;
    wire wr_dlim = wr_pend && wr_addr == scc_pkg::REG_DLIM;
    wire wr_time = wr_pend && wr_addr == scc_pkg::REG_TIME;
    wire wr_cmd = wr_pend && wr_addr == scc_pkg::REG_CMD;
    // second stage only with two extra channels
    wire stage2_en = mmode >= scc_pkg::MMODE_TWO_FIRST;
    wire [1:0] s2_ref = (pair == scc_pkg::PAIR_SECOND_THIRD) ? 2'h1 : 2'h0;
    wire [1:0] s2_cmp = (pair == scc_pkg::PAIR_MAIN_SECOND) ? 2'h1 : 2'h2;
    wire [1:0] tick_last = 2'h0;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign sync_request = req_w;
    assign sync_ok = ok_w;
    assign sync_fail = fail_w;
    assign tick = div_cnt == 18'(CYCLES_PER_MS - 1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_phase && hwrite && rd_mapped;
            wr_addr <= rd_addr;
            if (addr_phase && !hwrite) begin
                hrdata <= rd_val;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= scc_pkg::CTRL_RESET;
            vlim <= scc_pkg::VLIM_RESET;
            dlim <= scc_pkg::DLIM_RESET;
            tim <= scc_pkg::TIME_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= {22'h000000, hwdata[9:0]};
            end
            if (wr_vlim) begin
                vlim <= {16'h0000, hwdata[15:0]};
            end
            if (wr_dlim) begin
                dlim <= {9'h000, hwdata[22:0]};
            end
            if (wr_time) begin
                tim <= {3'h0, hwdata[28:16], 6'h00, hwdata[9:0]};
            end
        end
    end

    // software or pin close becomes request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_pulse <= 2'h0;
        end else begin
            cmd_pulse <= (wr_cmd ? hwdata[1:0] : 2'h0) | close_cmd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 18'h00000;
        end else if (tick) begin
            div_cnt <= 18'h00000;
        end else begin
            div_cnt <= div_cnt + 18'h00001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 3; i++) begin
                m_v[i] <= 8'h00;
                m_f[i] <= 16'h0000;
                m_p[i] <= 9'h000;
            end
        end else if (meas_valid) begin
            m_v[0] <= main_line_to_line_voltage;
            m_v[1] <= second_channel_voltage;
            m_v[2] <= third_channel_voltage;
            m_f[0] <= main_freq;
            m_f[1] <= second_freq;
            m_f[2] <= third_freq;
            m_p[0] <= main_phase;
            m_p[1] <= second_phase;
            m_p[2] <= third_phase;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cb_close <= 2'h0;
            object_fail <= 2'h0;
        end else begin
            cb_close <= close_w;
            object_fail <= objf_w;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_stage
            // stage 1 fixed main against second
            wire [1:0] ri = (g == 0) ? tick_last : s2_ref;
            wire [1:0] ci = (g == 0) ? 2'h1 : s2_cmp;
            assign st_if[g].tick = tick;
            assign st_if[g].enable = (g == 0) ? 1'b1 : stage2_en;
            assign st_if[g].bypass = bypass[g];
            assign st_if[g].smode = smode;
            assign st_if[g].umode = umode;
            assign st_if[g].dead_lim = vlim[7:0];
            assign st_if[g].live_lim = vlim[scc_pkg::VLIM_LIVE_LSB +: 8];
            assign st_if[g].df_lim = dlim[9:0];
            assign st_if[g].dv_lim = dlim[scc_pkg::DLIM_DV_LSB +: 6];
            assign st_if[g].ang_lim = dlim[scc_pkg::DLIM_ANG_LSB +: 7];
            assign st_if[g].cb_ms = tim[9:0];
            assign st_if[g].tout = tim[scc_pkg::TIME_TOUT_LSB +: 13];
            assign st_if[g].v_ref = m_v[ri];
            assign st_if[g].v_cmp = m_v[ci];
            assign st_if[g].f_ref = m_f[ri];
            assign st_if[g].f_cmp = m_f[ci];
            assign st_if[g].p_ref = m_p[ri];
            assign st_if[g].p_cmp = m_p[ci];
            assign st_if[g].start = cmd_pulse[g];
            assign st_if[g].cb_closed = cb_closed[g];
            assign req_w[g] = st_if[g].req;
            assign ok_w[g] = st_if[g].ok && st_if[g].enable;
            assign fail_w[g] = st_if[g].fail;
            assign close_w[g] = st_if[g].close;
            assign objf_w[g] = st_if[g].obj_fail;
            scc_stage u_stage (
                .hclk(hclk),
                .hresetn(hresetn),
                .s(st_if[g])
            );
        end
    endgenerate
endmodule

// file: bench/scc_sync_check_asserts.sv
`timescale 1ns/1ps
module scc_sync_check_asserts #(
    parameter int CYCLES_PER_MS = scc_pkg::CYCLES_PER_MS
) (
    // clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    // stage inputs and outputs
    input wire logic meas_valid,
    input wire logic [1:0] bypass,
    input wire logic [1:0] cb_close,
    input wire logic [1:0] object_fail,
    input wire logic [1:0] sync_request,
    input wire logic [1:0] sync_ok,
    input wire logic [1:0] sync_fail
);
    localparam int FAIL_MIN = (scc_pkg::FAIL_PULSE_MS - 1) * CYCLES_PER_MS;
    localparam int FAIL_MAX = (scc_pkg::FAIL_PULSE_MS + 1) * CYCLES_PER_MS;
    int fail_cnt;
    default clocking def_clk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // length of the running fail pulse in cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fail_cnt <= 0;
        end else begin
            fail_cnt <= sync_fail[0] ? fail_cnt + 1 : 0;
        end
    end
    AST_REQ_FAIL_EXCL: assert property (!(sync_request[0] && sync_fail[0]))
        else $error("request and fail high together");
    AST_FAIL_ENDS_REQ: assert property ($rose(sync_fail[0]) |-> $fell(sync_request[0]))
        else $error("fail rose without request ending");
    AST_FAIL_LEN: assert property ($fell(sync_fail[0]) |->
        fail_cnt >= FAIL_MIN && fail_cnt <= FAIL_MAX)
        else $error("fail pulse length wrong");
    AST_CLOSE_AFTER_REQ: assert property (cb_close[0] |->
        !$past(sync_request[0]) && $past(sync_request[0], 2))
        else $error("close without ended request");
    AST_CLOSE_PULSE: assert property (cb_close[0] |=> !cb_close[0])
        else $error("close longer than one cycle");
    AST_OK_BYPASS: assert property (bypass[0] |-> sync_ok[0])
        else $error("bypass without ok");
    AST_OK_CAUSE: assert property ($changed(sync_ok[0]) |-> $past(meas_valid)
        || $changed(bypass[0]) || ($past(hsel, 2) && $past(htrans[1], 2)))
        else $error("ok changed without cause");
    AST_OBJ_FAIL: assert property (object_fail[0] |-> !sync_request[0] ##1 !object_fail[0])
        else $error("object fail malformed");
    COV_CLOSE: cover property (cb_close[0]);
    COV_FAIL: cover property ($rose(sync_fail[0]));
    COV_OBJ: cover property (object_fail[0]);
endmodule

bind scc_sync_check scc_sync_check_asserts #(.CYCLES_PER_MS(CYCLES_PER_MS)) scc_asserts_inst (
    .hclk, .hresetn, .hsel, .htrans, .meas_valid, .bypass, .cb_close, .object_fail,
    .sync_request, .sync_ok, .sync_fail);

// file: bench/scc_far_end.sv
`timescale 1ns/1ps
module scc_far_end (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // breaker
    input wire logic [1:0] cb_close,
    input wire logic operate,
    output logic [1:0] cb_closed,
    // measurements
    output logic meas_valid,
    output logic [7:0] v_main, v_sec, v_thr,
    output logic [15:0] f_main, f_sec, f_thr,
    output logic [8:0] p_main, p_sec, p_thr
);
    logic [2:0] slot;
    logic [7:0] vm, vs, vt;
    logic [15:0] fm, fs;
    logic [8:0] pm, ps;
    // lines carry junk outside the strobe
    assign v_main = meas_valid ? vm : ~vm;
    assign v_sec = meas_valid ? vs : ~vs;
    assign v_thr = meas_valid ? vt : ~vt;
    assign f_main = meas_valid ? fm : ~fm;
    assign f_sec = meas_valid ? fs : ~fs;
    assign f_thr = meas_valid ? fm : ~fm;
    assign p_main = meas_valid ? pm : ~pm;
    assign p_sec = meas_valid ? ps : ~ps;
    assign p_thr = meas_valid ? pm : ~pm;
    task automatic set_meas(input logic [7:0] a, b, c, input logic [15:0] fa, fb,
        input logic [8:0] pa, pb);
        vm = a;
        vs = b;
        vt = c;
        fm = fa;
        fs = fb;
        pm = pa;
        ps = pb;
    endtask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot <= 3'h0;
            meas_valid <= 1'b0;
            cb_closed <= 2'h0;
        end else begin
            slot <= slot + 3'h1;
            meas_valid <= (slot == 3'h7);
            cb_closed <= operate ? (cb_closed | cb_close) : 2'h0;
        end
    end
endmodule

// file: bench/scc_sync_check_tb.sv
`timescale 1ns/1ps
module scc_sync_check_tb;
    localparam int CPM = 10;
    localparam int TOUT = scc_pkg::TIMEOUT_UNIT_MS * CPM;
    localparam int FAIL = scc_pkg::FAIL_PULSE_MS * CPM;
    localparam int OBJ = scc_pkg::OBJ_FAIL_MS * CPM;
    localparam logic [7:0] DV = scc_pkg::VLIM_RESET[7:0];
    localparam logic [7:0] LV = scc_pkg::VLIM_RESET[15:8];
    localparam logic [31:0] A_CTRL = {24'h0, scc_pkg::REG_CTRL};
    localparam logic [31:0] A_TIME = {24'h0, scc_pkg::REG_TIME};
    localparam logic [31:0] A_CMD = {24'h0, scc_pkg::REG_CMD};
    localparam logic [31:0] A_STAT = {24'h0, scc_pkg::REG_STATUS};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, meas_valid, operate;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] v_main, v_sec, v_thr;
    logic [15:0] f_main, f_sec, f_thr;
    logic [8:0] p_main, p_sec, p_thr;
    logic [1:0] close_cmd, cb_closed, bypass, cb_close, object_fail;
    logic [1:0] sync_request, sync_ok, sync_fail;
    int err_count = 0;
    int comparisons = 0;
    scc_sync_check #(.CYCLES_PER_MS(CPM)) scc_sync_check_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .meas_valid,
        .main_line_to_line_voltage(v_main), .second_channel_voltage(v_sec),
        .third_channel_voltage(v_thr), .main_freq(f_main), .second_freq(f_sec),
        .third_freq(f_thr), .main_phase(p_main), .second_phase(p_sec),
        .third_phase(p_thr), .close_cmd, .cb_closed, .bypass, .cb_close,
        .object_fail, .sync_request, .sync_ok, .sync_fail);
    scc_far_end scc_far_end_inst (.hclk, .hresetn, .cb_close, .operate, .cb_closed,
        .meas_valid, .v_main, .v_sec, .v_thr, .f_main, .f_sec, .f_thr, .p_main,
        .p_sec, .p_thr);
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic close_out;
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        close_out();
    end
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
        repeat (2) @(posedge hclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        check("rdata", q, e);
        check("hresp", hresp, 1'b0);
    endtask
    task automatic meas(input logic [7:0] a, b, c, input logic [15:0] fa, fb,
        input logic [8:0] pa, pb);
        scc_far_end_inst.set_meas(a, b, c, fa, fb, pa, pb);
        repeat (12) @(posedge hclk);
    endtask
    function automatic logic seen(input int s);
        case (s)
            0: seen = cb_close[0] | sync_fail[0];
            1: seen = ~sync_fail[0];
            2: seen = object_fail[0];
            default: seen = cb_close[0];
        endcase
    endfunction
    task automatic wait_for(input int s, input int lim, output int n);
        n = 0;
        while (seen(s) !== 1'b1 && n < lim) begin
            @(posedge hclk);
            #1;
            n++;
        end
    endtask
    task automatic run_req(input logic exp_close);
        int n;
        @(posedge hclk);
        close_cmd <= 2'h1;
        @(posedge hclk);
        close_cmd <= 2'h0;
        @(posedge hclk);
        #1;
        check("req_start", {sync_request[0], cb_close[0]}, 2'b10);
        wait_for(0, TOUT + 200, n);
        check("closed", cb_close[0], exp_close);
        if (exp_close) begin
            check("close_lat", n <= 3, 1'b1);
        end else begin
            check("tout", n >= TOUT - CPM && n <= TOUT + CPM, 1'b1);
            check("req_end", sync_request[0], 1'b0);
            wait_for(1, FAIL + 1000, n);
            check("fail_len", n >= FAIL - CPM && n <= FAIL + CPM, 1'b1);
        end
        repeat (4) @(posedge hclk);
    endtask
    task automatic t_regs;
        rd(A_CTRL, scc_pkg::CTRL_RESET);
        rd({24'h0, scc_pkg::REG_VLIM}, scc_pkg::VLIM_RESET);
        rd({24'h0, scc_pkg::REG_DLIM}, scc_pkg::DLIM_RESET);
        rd(A_TIME, scc_pkg::TIME_RESET);
        rd(A_CMD, 32'h0);
        rd(32'h18, 32'h0);
        wr(32'h100, 32'h1);
        rd(32'h100, 32'h0);
        wr(A_CTRL, 32'h295);
        rd(A_CTRL, 32'h295);
    endtask
    task automatic t_vcheck;
        logic [7:0] r[5] = '{8'h13, 8'h13, 8'h51, 8'h14, 8'h13};
        logic [7:0] c[5] = '{8'h13, 8'h51, 8'h13, 8'h51, 8'h50};
        logic [2:0] mask[7] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6, 3'h7};
        logic [2:0] kind;
        for (int i = 0; i < 5; i++) begin
            meas(r[i], c[i], r[i], 16'hc350, 16'hc350, 9'h0, 9'h0);
            kind = {r[i] > LV && c[i] < DV, r[i] < DV && c[i] > LV, r[i] < DV && c[i] < DV};
            for (int m = 0; m < 7; m++) begin
                wr(A_CTRL, 32'(m) << scc_pkg::CTRL_UMODE_LSB);
                check("ok_vc", sync_ok[0], |(mask[m] & kind));
            end
        end
    endtask
    task automatic t_pairs;
        meas(8'h13, 8'h5a, 8'h13, 16'hc350, 16'hc350, 9'h0, 9'h0);
        for (int p = 0; p < 4; p++) begin
            wr(A_CTRL, (32'(p < 3 ? scc_pkg::MMODE_TWO_FIRST : 3'h0) << scc_pkg::CTRL_MMODE_LSB)
                | (32'(p < 3 ? p : 1) << scc_pkg::CTRL_PAIR_LSB));
            check("ok_pair", sync_ok, {p == 1, 1'b0});
        end
        wr(A_CMD, 32'h2);
        check("req2_off", sync_request, 2'h0);
    endtask
    task automatic t_crit;
        logic [7:0] va[6] = '{8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h46, 8'h5a};
        logic [7:0] vb[6] = '{8'h5a, 8'h5f, 8'h5a, 8'h5a, 8'h46, 8'h5a};
        logic [15:0] fb[6] = '{16'hc350, 16'hc382, 16'hc47c, 16'hc382, 16'hc382, 16'hc382};
        logic [8:0] pb[6] = '{9'h15e, 9'h00a, 9'h00a, 9'h028, 9'h00a, 9'h00a};
        logic [5:0] e = 6'b100001;
        wr(A_CTRL, 32'(scc_pkg::SMODE_ASYNC));
        for (int i = 0; i < 6; i++) begin
            meas(va[i], vb[i], va[i], 16'hc350, fb[i], 9'h0, pb[i]);
            check("ok_crit", sync_ok[0], e[i]);
        end
    endtask
    task automatic t_object;
        int n;
        wait_for(2, OBJ + 200, n);
        check("obj_quiet", object_fail[0], 1'b0);
        operate <= 1'b0;
        wr(A_CMD, 32'h1);
        wait_for(3, 20, n);
        check("cmd_close", cb_close[0], 1'b1);
        wait_for(2, OBJ + 200, n);
        check("obj_fail", n >= OBJ - CPM && n <= OBJ + CPM, 1'b1);
        operate <= 1'b1;
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        close_cmd = 2'h0;
        bypass = 2'h0;
        operate = 1'b1;
        scc_far_end_inst.set_meas(8'h0, 8'h0, 8'h0, 16'h0, 16'h0, 9'h0, 9'h0);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_vcheck();
        t_pairs();
        t_crit();
        wr(A_TIME, (32'h1 << scc_pkg::TIME_TOUT_LSB) | 32'h64);
        run_req(1'b1);
        t_object();
        wr(A_CTRL, 32'(scc_pkg::SMODE_SYNC));
        run_req(1'b0);
        meas(8'h5a, 8'h5a, 8'h5a, 16'hc350, 16'hc382, 9'h0, 9'h167);
        run_req(1'b1);
        wr(A_CTRL, 32'h0);
        check("ok_off", sync_ok[0], 1'b0);
        run_req(1'b0);
        bypass <= 2'h1;
        repeat (2) @(posedge hclk);
        check("ok_byp", sync_ok[0], 1'b1);
        rd(A_STAT, 32'h4);
        run_req(1'b1);
        bypass <= 2'h0;
        close_out();
    end
endmodule
